// >>> shared/hwmon_pkg.sv
// constants for the hardware-monitor limit, status and interrupt block
// assumes one device clock; all offsets are byte addresses on the serial bus
package hwmon_pkg;

  // ----------------------------------------------------------------------
  // channel layout
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int NUM_TEMP = 3;
  localparam int NUM_FAN = 4;
  localparam int CH_REMOTE1 = 0;
  localparam int CH_REMOTE2 = 2;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_START_LOCK = 8'h40;
  localparam logic [7:0] REG_STATUS1 = 8'h41;
  localparam logic [7:0] REG_STATUS2 = 8'h42;
  localparam logic [7:0] REG_CPU_VID = 8'h43;
  localparam logic [7:0] REG_SPECIAL = 8'h7C;
  localparam logic [7:0] REG_DIODE_CTRL = 8'h7D;
  localparam logic [7:0] REG_CONFIG = 8'h7F;
  localparam logic [7:0] REG_FAN_TEMP_EN = 8'h80;
  // channel order: remote1, internal, remote2, then five supplies
  localparam logic [7:0] READ_ADDR [NUM_CH] = '{8'h25, 8'h26, 8'h27,
    8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
  localparam logic [7:0] LO_ADDR [NUM_CH] = '{8'h4E, 8'h50, 8'h52,
    8'h44, 8'h46, 8'h48, 8'h4A, 8'h4C};
  localparam logic [7:0] HI_ADDR [NUM_CH] = '{8'h4F, 8'h51, 8'h53,
    8'h45, 8'h47, 8'h49, 8'h4B, 8'h4D};

  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0] LO_RESET [NUM_CH] = '{8'h81, 8'h81, 8'h81,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] HI_RESET [NUM_CH] = '{8'h7F, 8'h7F, 8'h7F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] SPECIAL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] FAN_TEMP_EN_RESET = 8'h00;
  localparam logic [1:0] DIODE_CTRL_RESET = 2'h0;
  localparam logic [7:0] CONFIG_WR_MASK = 8'h7F;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int START_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int SPECIAL_SHUTDOWN_BIT = 0;
  localparam int SPECIAL_INT_EN_BIT = 2;
  localparam int SPECIAL_VOLT_EN_BIT = 3;
  localparam int CONFIG_INT_PIN_BIT = 1;
  localparam int CONFIG_SOFT_RST_BIT = 7;
  localparam int FTE_FAN_EN_BIT = 0;
  localparam int FTE_TEMP_EN_BIT = 5;
  localparam int ST2_FAN_LSB = 2;
  localparam int ST2_DIODE_LSB = 6;

  // ----------------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] DIODE_FAULT_CODE = 8'h80;
  localparam logic [7:0] DIODE_OFF_CODE = 8'h00;
  localparam logic [6:0] ARA_ADDR = 7'h0C;

endpackage : hwmon_pkg

// >>> core/limit_window.sv
// one monitored channel: reading register, window compare, sticky flag
// assumes load, clr and srst are single-cycle strobes on clk
`timescale 1ns/100ps
`default_nettype none

module limit_window #(
  parameter bit SIGNED_CMP = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic srst,
  input wire logic run,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic [7:0] low,
  input wire logic [7:0] high,
  input wire logic clr,
  output logic [7:0] reading_q,
  output logic violate,
  output logic flag_q
);

  logic new_violate;

  // ----------------------------------------------------------------------
  // compare: outside the window or equal to either limit
  // ----------------------------------------------------------------------
  function automatic logic outside(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
    if (SIGNED_CMP) begin
      return ($signed(v) <= $signed(lo)) || ($signed(v) >= $signed(hi));
    end
    return (v <= lo) || (v >= hi);
  endfunction : outside

  assign violate = outside(reading_q, low, high);
  assign new_violate = outside(load_data, low, high);

  // reading keeps its value over soft reset and low-power modes
  always_ff @(posedge clk) begin
    if (rst) begin
      reading_q <= 8'h00;
    end else if (ce && run && load) begin
      reading_q <= load_data;
    end
  end

  // sticky flag; a new violation wins over a read clear
  always_ff @(posedge clk) begin
    if (rst || (ce && srst)) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (run && load && new_violate) begin
        flag_q <= 1'b1;
      end else if (clr && !violate) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule : limit_window

`default_nettype wire

// >>> core/hwmon_irq_core.sv
// serial-bus slave, register file, limit status and interrupt pin logic
// assumes scl/sda/vid from pins; conversion results and fan errors on clk
`timescale 1ns/100ps
`default_nettype none

module hwmon_irq_core
  import hwmon_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2D
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic smb_scl_i,
  input wire logic smb_sda_i,
  output logic smb_sda_o,
  output logic smb_sda_oe_n,
  output logic int_n_o,
  output logic int_n_oe_n,
  input wire logic [4:0] cpu_voltage_code_inputs,
  input wire logic conv_valid,
  input wire logic [2:0] conv_channel,
  input wire logic [7:0] conv_data,
  input wire logic [1:0] diode_fault,
  input wire logic [NUM_FAN-1:0] fan_error,
  output logic monitor_run,
  output logic bias_enable,
  output logic pwm_full
);

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_ADDR, S_PTR, S_ACK_PTR, S_WR, S_ACK_WR, S_RD,
    S_ACK_RD
  } smb_state_t;

  smb_state_t st_q;
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic scl_rise, scl_fall, start_det, stop_det, bus_evt;
  logic [3:0] bit_q;
  logic [7:0] shift_q, tx_q, ptr_q, rd_byte, tx_byte;
  logic sda_low_q, rw_q, ara_q, addr_hit, ara_hit;
  logic load_tx, wr_stb, srst, clr1, clr2;
  logic start_q, lock_q, ara_mask_q, int_active_q;
  logic [7:0] special_q, config_q, fte_q;
  logic [1:0] diode_dis_q, diode_flag_q, fault_lvl_q;
  logic [NUM_FAN-1:0] fan_flag_q;
  logic [4:0] vid_m_q, vid_s_q, vid_q;
  logic [7:0] lo_q [NUM_CH];
  logic [7:0] hi_q [NUM_CH];
  logic [7:0] reading_w [NUM_CH];
  logic [7:0] load_data [NUM_CH];
  logic [NUM_CH-1:0] load, violate_w, flag_w;
  logic [7:0] status1, status2;
  logic temp_any, volt_any, fan_any, irq_src;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // two flops per pin, a third copy for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_m_q <= smb_scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= smb_sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // voltage-id pins synchronised then held in their register
  always_ff @(posedge clk) begin
    if (rst) begin
      vid_m_q <= 5'h00;
      vid_s_q <= 5'h00;
      vid_q <= 5'h00;
    end else if (ce) begin
      vid_m_q <= cpu_voltage_code_inputs;
      vid_s_q <= vid_m_q;
      vid_q <= vid_s_q;
    end
  end

  // ----------------------------------------------------------------------
  // serial-bus slave
  // ----------------------------------------------------------------------
  // bus conditions and the strobes handed to the register file
  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;
  assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_det = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
  assign bus_evt = scl_fall && !start_det && !stop_det;
  assign addr_hit = (shift_q[7:1] == DEV_ADDR);
  assign ara_hit = (shift_q[7:1] == ARA_ADDR) && shift_q[0] && int_active_q;
  assign load_tx = bus_evt && (((st_q == S_ACK_ADDR) && rw_q) ||
                   (st_q == S_ACK_RD));
  assign wr_stb = bus_evt && (st_q == S_WR) && (bit_q == 4'h8);
  assign tx_byte = ara_q ? {DEV_ADDR, 1'b0} : rd_byte;
  assign clr1 = load_tx && !ara_q && (ptr_q == REG_STATUS1);
  assign clr2 = load_tx && !ara_q && (ptr_q == REG_STATUS2);
  assign smb_sda_o = 1'b0;
  assign smb_sda_oe_n = !sda_low_q;

  // byte framing, acknowledge and data shifting on scl edges
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      sda_low_q <= 1'b0;
      rw_q <= 1'b0;
      ara_q <= 1'b0;
    end else if (ce) begin
      if (start_det) begin
        st_q <= S_ADDR;
        bit_q <= 4'h0;
        sda_low_q <= 1'b0;
      end else if (stop_det) begin
        st_q <= S_IDLE;
        sda_low_q <= 1'b0;
      end else if (scl_rise) begin
        if (st_q inside {S_ADDR, S_PTR, S_WR}) begin
          shift_q <= {shift_q[6:0], sda_s_q};
          bit_q <= bit_q + 4'h1;
        end else if ((st_q == S_ACK_RD) && sda_s_q) begin
          st_q <= S_IDLE; // host ends the read with a nack
        end
      end else if (scl_fall) begin
        unique case (st_q)
          S_IDLE: begin
          end
          S_ADDR: begin
            if (bit_q == 4'h8) begin
              if (addr_hit || ara_hit) begin
                sda_low_q <= 1'b1;
                rw_q <= shift_q[0];
                ara_q <= ara_hit;
                st_q <= S_ACK_ADDR;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_PTR, S_WR: begin
            if (bit_q == 4'h8) begin
              sda_low_q <= 1'b1;
              st_q <= (st_q == S_PTR) ? S_ACK_PTR : S_ACK_WR;
            end
          end
          S_ACK_PTR, S_ACK_WR: begin
            sda_low_q <= 1'b0;
            bit_q <= 4'h0;
            st_q <= S_WR;
          end
          S_ACK_ADDR, S_ACK_RD: begin
            if (load_tx) begin
              tx_q <= tx_byte;
              sda_low_q <= !tx_byte[7];
              bit_q <= 4'h1;
              st_q <= S_RD;
            end else begin
              sda_low_q <= 1'b0;
              bit_q <= 4'h0;
              st_q <= S_PTR;
            end
          end
          S_RD: begin
            if (bit_q == 4'h8) begin
              sda_low_q <= 1'b0;
              st_q <= S_ACK_RD;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_low_q <= !tx_q[6];
              bit_q <= bit_q + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // register pointer: set by the first written byte, then auto-increments
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= 8'h00;
    end else if (ce) begin
      if (bus_evt && (st_q == S_PTR) && (bit_q == 4'h8)) begin
        ptr_q <= shift_q;
      end else if (wr_stb || (load_tx && !ara_q)) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  // soft reset is a write of one to the config top bit; it self-clears
  assign srst = wr_stb && (ptr_q == REG_CONFIG) &&
                shift_q[CONFIG_SOFT_RST_BIT];

  // start, lock, special function, config, event enables, diode disables
  always_ff @(posedge clk) begin
    if (rst || (ce && srst)) begin
      start_q <= 1'b0;
      lock_q <= 1'b0;
      special_q <= SPECIAL_RESET;
      config_q <= CONFIG_RESET;
      fte_q <= FAN_TEMP_EN_RESET;
      diode_dis_q <= DIODE_CTRL_RESET;
    end else if (ce && wr_stb) begin
      unique case (ptr_q)
        REG_START_LOCK: begin
          start_q <= shift_q[START_BIT];
          lock_q <= lock_q || shift_q[LOCK_BIT];
        end
        REG_SPECIAL: special_q <= shift_q;
        REG_CONFIG: config_q <= shift_q & CONFIG_WR_MASK;
        REG_FAN_TEMP_EN: fte_q <= shift_q;
        REG_DIODE_CTRL: diode_dis_q <= shift_q[1:0];
        default: begin
        end
      endcase
    end
  end

  // limits stay writable in low power; lock freezes them until reset
  always_ff @(posedge clk) begin
    if (rst || (ce && srst)) begin
      for (int i = 0; i < NUM_CH; i++) begin
        lo_q[i] <= LO_RESET[i];
        hi_q[i] <= HI_RESET[i];
      end
    end else if (ce && wr_stb && !lock_q) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ptr_q == LO_ADDR[i]) begin
          lo_q[i] <= shift_q;
        end
        if (ptr_q == HI_ADDR[i]) begin
          hi_q[i] <= shift_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // readings and status
  // ----------------------------------------------------------------------
  // remote diode faults replace the converted code
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      load[i] = conv_valid && (conv_channel == 3'(i));
      load_data[i] = conv_data;
    end
    for (int j = 0; j < 2; j++) begin
      if (diode_fault[j]) begin
        load_data[2 * j] = diode_dis_q[j] ? DIODE_OFF_CODE
                                          : DIODE_FAULT_CODE;
      end
    end
  end

  // one window per channel; the three temperatures compare signed
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    limit_window #(
      .SIGNED_CMP(g < NUM_TEMP)
    ) u_win (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .srst(srst),
      .run(start_q),
      .load(load[g]),
      .load_data(load_data[g]),
      .low(lo_q[g]),
      .high(hi_q[g]),
      .clr(clr1),
      .reading_q(reading_w[g]),
      .violate(violate_w[g]),
      .flag_q(flag_w[g])
    );
  end

  // diode fault flags: level kept from the last remote conversion
  always_ff @(posedge clk) begin
    if (rst || (ce && srst)) begin
      fault_lvl_q <= 2'h0;
      diode_flag_q <= 2'h0;
    end else if (ce) begin
      for (int j = 0; j < 2; j++) begin
        if (start_q && load[2 * j]) begin
          fault_lvl_q[j] <= diode_fault[j] && !diode_dis_q[j];
        end
        if (start_q && load[2 * j] && diode_fault[j] && !diode_dis_q[j]) begin
          diode_flag_q[j] <= 1'b1;
        end else if (clr2 && !fault_lvl_q[j]) begin
          diode_flag_q[j] <= 1'b0;
        end
      end
    end
  end

  // fan error flags; while started, a still-present error survives the read
  always_ff @(posedge clk) begin
    if (rst || (ce && srst)) begin
      fan_flag_q <= '0;
    end else if (ce) begin
      for (int k = 0; k < NUM_FAN; k++) begin
        if (start_q && fan_error[k]) begin
          fan_flag_q[k] <= 1'b1;
        end else if (clr2) begin
          fan_flag_q[k] <= 1'b0;
        end
      end
    end
  end

  // status layout: supplies low, zones 1..3 in the top three bits
  assign status1 = {flag_w[2], flag_w[1], flag_w[0], flag_w[7:3]};
  assign status2 = {diode_flag_q, fan_flag_q, 2'h0};

  // register read mux; unmapped offsets read zero
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ptr_q == READ_ADDR[i]) begin
        rd_byte = reading_w[i];
      end
      if (ptr_q == LO_ADDR[i]) begin
        rd_byte = lo_q[i];
      end
      if (ptr_q == HI_ADDR[i]) begin
        rd_byte = hi_q[i];
      end
    end
    unique case (ptr_q)
      REG_START_LOCK: rd_byte = {6'h00, lock_q, start_q};
      REG_STATUS1: rd_byte = status1;
      REG_STATUS2: rd_byte = status2;
      REG_CPU_VID: rd_byte = {3'h0, vid_q};
      REG_SPECIAL: rd_byte = special_q;
      REG_DIODE_CTRL: rd_byte = {6'h00, diode_dis_q};
      REG_CONFIG: rd_byte = config_q;
      REG_FAN_TEMP_EN: rd_byte = fte_q;
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------------
  // event groups; diode fault flags are deliberately left out
  assign temp_any = |flag_w[NUM_TEMP-1:0];
  assign volt_any = |flag_w[NUM_CH-1:NUM_TEMP];
  assign fan_any = |fan_flag_q;
  assign irq_src = (fte_q[FTE_TEMP_EN_BIT] && temp_any) ||
                   (special_q[SPECIAL_VOLT_EN_BIT] && volt_any) ||
                   (fte_q[FTE_FAN_EN_BIT] && fan_any);

  // alert response masks the pin until the events go or status is read
  always_ff @(posedge clk) begin
    if (rst || (ce && srst)) begin
      ara_mask_q <= 1'b0;
    end else if (ce) begin
      if (load_tx && ara_q) begin
        ara_mask_q <= 1'b1;
      end else if (!irq_src || clr1 || clr2) begin
        ara_mask_q <= 1'b0;
      end
    end
  end

  // pin drives low only when every gate is open
  always_ff @(posedge clk) begin
    if (rst) begin
      int_active_q <= 1'b0;
    end else if (ce) begin
      int_active_q <= config_q[CONFIG_INT_PIN_BIT] &&
                      special_q[SPECIAL_INT_EN_BIT] &&
                      start_q && irq_src && !ara_mask_q;
    end
  end

  assign int_n_o = 1'b0;
  assign int_n_oe_n = !int_active_q;

  // ----------------------------------------------------------------------
  // power mode outputs
  // ----------------------------------------------------------------------
  // stopped monitor: converter off, fans full, bias per shutdown select
  always_ff @(posedge clk) begin
    if (rst) begin
      monitor_run <= 1'b0;
      pwm_full <= 1'b1;
      bias_enable <= 1'b1;
    end else if (ce) begin
      monitor_run <= start_q;
      pwm_full <= !start_q;
      bias_enable <= start_q || !special_q[SPECIAL_SHUTDOWN_BIT];
    end
  end

endmodule : hwmon_irq_core

`default_nettype wire

// >>> tb/hwmon_irq_chk.sv
// checker: port-level relations of the monitor interrupt block
// assumes a bind onto hwmon_irq_core, one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module hwmon_irq_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic smb_scl_i,
  input wire logic smb_sda_i,
  input wire logic smb_sda_o,
  input wire logic smb_sda_oe_n,
  input wire logic int_n_o,
  input wire logic int_n_oe_n,
  input wire logic monitor_run,
  input wire logic bias_enable,
  input wire logic pwm_full
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic scl_q, sda_q;
  logic [4:0] idle_q;
  // cycles since a bus pin last moved, saturating
  always_ff @(posedge clk) begin
    scl_q <= smb_scl_i;
    sda_q <= smb_sda_i;
    if (rst || scl_q != smb_scl_i || sda_q != smb_sda_i) idle_q <= 5'h00;
    else if (idle_q != 5'h1F) idle_q <= idle_q + 5'h01;
  end
  a_reset_idle_pins: assert property ($fell(rst) |-> int_n_oe_n &&
    smb_sda_oe_n && !monitor_run && pwm_full && bias_enable)
    else $error("outputs not idle after reset");
  a_stopped_no_int: assert property (!monitor_run |=> int_n_oe_n)
    else $error("interrupt active while stopped");
  a_fans_full_idle: assert property (pwm_full == !monitor_run)
    else $error("fan full drive wrong for mode");
  a_bias_while_run: assert property (monitor_run |-> bias_enable)
    else $error("bias off while running");
  a_int_fall_run: assert property ($fell(int_n_oe_n) |-> monitor_run)
    else $error("interrupt asserted without monitor running");
  a_pin_pulls_low: assert property (int_n_o == 1'b0 && smb_sda_o == 1'b0)
    else $error("open-drain data not low");
  a_start_needs_bus: assert property ($rose(monitor_run) |-> idle_q < 5'h10)
    else $error("monitor started without bus write");
  a_int_flag_sticky: assert property ($rose(int_n_oe_n) |->
    idle_q < 5'h10 || !$past(monitor_run))
    else $error("interrupt released without bus or stop");
  c_int_low: cover property (!int_n_oe_n);
  c_started: cover property ($rose(monitor_run));
  c_shutdown: cover property ($fell(bias_enable));
endmodule : hwmon_irq_chk
bind hwmon_irq_core hwmon_irq_chk u_chk (.clk(clk), .rst(rst),
  .smb_scl_i(smb_scl_i), .smb_sda_i(smb_sda_i), .smb_sda_o(smb_sda_o),
  .smb_sda_oe_n(smb_sda_oe_n), .int_n_o(int_n_o), .int_n_oe_n(int_n_oe_n),
  .monitor_run(monitor_run), .bias_enable(bias_enable), .pwm_full(pwm_full));
`default_nettype wire

// >>> tb/smb_host_model.sv
// partner: behavioural serial-bus host driving clock, sharing data
// assumes the device pulls data low through an active-low enable
`timescale 1ns/100ps
`default_nettype none
module smb_host_model
  import hwmon_pkg::*;
(
  input wire logic clk,
  input wire logic dev_sda_oe_n,
  output logic scl,
  output logic sda
);
  logic host_oe_n;
  logic [7:0] junk;
  logic k;
  // open-drain data wire with pull-up
  assign sda = host_oe_n & dev_sda_oe_n;
  initial begin
    scl = 1'b1;
    host_oe_n = 1'b1;
  end
  // half a bit time, six device clocks
  task automatic half();
    repeat (6) @(posedge clk);
    #1;
  endtask : half
  // eight data bits then the acknowledge bit, sampled before clock falls
  task automatic xfer(input logic [7:0] d, input logic ack,
    output logic [7:0] q, output logic a);
    for (int i = 8; i >= 0; i--) begin
      host_oe_n = (i == 0) ? ack : d[i-1];
      half();
      scl = 1'b1;
      half();
      if (i == 0) a = sda;
      else q[i-1] = sda;
      scl = 1'b0;
    end
  endtask : xfer
  // start or repeated start
  task automatic start();
    host_oe_n = 1'b1;
    half();
    scl = 1'b1;
    half();
    host_oe_n = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    host_oe_n = 1'b0;
    half();
    scl = 1'b1;
    half();
    host_oe_n = 1'b1;
    half();
  endtask : stop
  task automatic write(input logic [6:0] a, input logic [7:0] p, d);
    start();
    xfer({a, 1'b0}, 1'b1, junk, k);
    xfer(p, 1'b1, junk, k);
    xfer(d, 1'b1, junk, k);
    stop();
  endtask : write
  task automatic read(input logic [6:0] a, input logic [7:0] p,
    output logic [7:0] q);
    start();
    xfer({a, 1'b0}, 1'b1, junk, k);
    xfer(p, 1'b1, junk, k);
    start();
    xfer({a, 1'b1}, 1'b1, junk, k);
    xfer(8'hFF, 1'b1, q, k);
    stop();
  endtask : read
  // alert response call: one byte read at the shared address
  task automatic ara(output logic [7:0] q);
    start();
    xfer({ARA_ADDR, 1'b1}, 1'b1, junk, k);
    xfer(8'hFF, 1'b1, q, k);
    stop();
  endtask : ara
endmodule : smb_host_model
`default_nettype wire

// >>> tb/tb_hwmon_irq_core.sv
// testbench: registers over the serial bus, conversions, interrupt pin
// assumes the host model as bus partner and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb_hwmon_irq_core;
  import hwmon_pkg::*;
  localparam logic [6:0] slave_addr = 7'h2D; // arbitrary bus address
  logic clk, rst, ce, conv_valid, scl, sda, sda_o, sda_oe_n, int_o, int_oe_n;
  logic run, bias, pwm;
  logic [4:0] vid;
  logic [2:0] conv_ch;
  logic [7:0] conv_d, got;
  logic [1:0] dfault;
  logic [NUM_FAN-1:0] fan_err;
  logic [15:0] setup [7] = '{16'h7F02, 16'h7C0C, 16'h8021, 16'h50F0,
    16'h5120, 16'h7D02, 16'h4001};
  int fails, num_checks, cycles, seed;
  logic [7:0] exp_q [$];
  string name_q [$];
  event seen;
  hwmon_irq_core #(.DEV_ADDR(slave_addr)) u_dut (.clk(clk), .rst(rst),
    .ce(ce), .smb_scl_i(scl), .smb_sda_i(sda), .smb_sda_o(sda_o),
    .smb_sda_oe_n(sda_oe_n), .int_n_o(int_o), .int_n_oe_n(int_oe_n),
    .cpu_voltage_code_inputs(vid), .conv_valid(conv_valid),
    .conv_channel(conv_ch), .conv_data(conv_d), .diode_fault(dfault),
    .fan_error(fan_err), .monitor_run(run), .bias_enable(bias),
    .pwm_full(pwm));
  smb_host_model u_host (.clk(clk), .dev_sda_oe_n(sda_oe_n), .scl(scl),
    .sda(sda));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare each result with the oldest note
  always @(seen) begin
    num_checks++;
    if (got !== exp_q[0]) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name_q[0], exp_q[0], got);
    end
    void'(exp_q.pop_front());
    void'(name_q.pop_front());
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic look(input string n, input logic [7:0] e, g);
    exp_q.push_back(e);
    name_q.push_back(n);
    got = g;
    ->seen;
    @(posedge clk);
    #1;
  endtask : look
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] q;
    u_host.read(slave_addr, a, q);
    look($sformatf("reg %h", a), e, q);
  endtask : rd
  task automatic wr(input logic [7:0] a, d);
    u_host.write(slave_addr, a, d);
  endtask : wr
  // one conversion result, then time for flag and pin
  task automatic conv(input logic [2:0] c, input logic [7:0] d,
    input logic [1:0] f);
    conv_ch = c;
    conv_d = d;
    dfault = f;
    conv_valid = 1'b1;
    @(posedge clk);
    #1;
    conv_valid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : conv
  initial begin
    logic [7:0] q;
    seed = 38003;
    rst = 1'b1;
    ce = 1'b1;
    conv_valid = 1'b0;
    conv_ch = 3'h0;
    conv_d = 8'h00;
    dfault = 2'h0;
    fan_err = '0;
    vid = 5'($random(seed));
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rd(REG_SPECIAL, SPECIAL_RESET);
    rd(REG_CONFIG, CONFIG_RESET);
    rd(REG_FAN_TEMP_EN, FAN_TEMP_EN_RESET);
    rd(REG_CPU_VID, {3'h0, vid});
    // limits and enables first, start last
    foreach (setup[i]) wr(setup[i][15:8], setup[i][7:0]);
    look("run", 8'h01, {7'h00, run});
    look("pwm", 8'h00, {7'h00, pwm});
    // fan error alone drives the pin, read clears it once gone
    fan_err = 4'h1;
    conv(3'h4, 8'h80, 2'h0);
    look("int", 8'h00, {7'h00, int_oe_n});
    fan_err = '0;
    rd(REG_STATUS2, 8'h04);
    look("int", 8'h01, {7'h00, int_oe_n});
    // internal zone at its high limit, then back inside
    conv(3'h1, 8'h20, 2'h0);
    look("int", 8'h00, {7'h00, int_oe_n});
    rd(REG_STATUS1, 8'h40);
    conv(3'h1, 8'h05, 2'h0);
    rd(REG_STATUS1, 8'h40);
    rd(REG_STATUS1, 8'h00);
    look("int", 8'h01, {7'h00, int_oe_n});
    // supply: random inside value, then equal to the low limit
    conv(3'h3, 8'h01 + 8'({$random(seed)} % 254), 2'h0);
    rd(REG_STATUS1, 8'h00);
    conv(3'h3, 8'h00, 2'h0);
    look("int", 8'h00, {7'h00, int_oe_n});
    conv(3'h3, 8'h80, 2'h0);
    rd(REG_STATUS1, 8'h01);
    rd(REG_STATUS1, 8'h00);
    // diode faults: enabled one, then disabled one
    conv(3'h0, 8'h33, 2'h1);
    rd(8'h25, DIODE_FAULT_CODE);
    rd(REG_STATUS2, 8'h40);
    conv(3'h2, 8'h33, 2'h2);
    rd(8'h27, DIODE_OFF_CODE);
    rd(REG_STATUS1, 8'h20);
    look("int", 8'h00, {7'h00, int_oe_n});
    // global enable off and on again, then alert response
    wr(REG_SPECIAL, 8'h08);
    look("int", 8'h01, {7'h00, int_oe_n});
    wr(REG_SPECIAL, 8'h0C);
    look("int", 8'h00, {7'h00, int_oe_n});
    u_host.ara(q);
    look("ara", {slave_addr, 1'b0}, q);
    look("int", 8'h01, {7'h00, int_oe_n});
    // sleep, conversions ignored, registers kept, then shutdown
    // clock enable low: this conversion must not land
    ce = 1'b0;
    conv(3'h1, 8'h7F, 2'h0);
    ce = 1'b1;
    wr(REG_START_LOCK, 8'h00);
    look("run", 8'h00, {7'h00, run});
    look("pwm", 8'h01, {7'h00, pwm});
    look("bias", 8'h01, {7'h00, bias});
    conv(3'h1, 8'h7F, 2'h0);
    rd(8'h26, 8'h05);
    rd(8'h51, 8'h20);
    wr(REG_SPECIAL, 8'h01);
    look("bias", 8'h00, {7'h00, bias});
    stop_test();
  end
endmodule : tb_hwmon_irq_core
`default_nettype wire
